// >>> interlock_group_supervisor.sv
// What this block does
// - master or zone role locks out when configured role mismatches base switch
// - connected zone count 1..16 is honoured only in master role
// - new zone count applied on link error clear, count error clear or restart
// - master stops everything once faulted zones reach threshold 1..16
// - a single faulted zone locks itself and blocks its burners only
// - two or more faulted units lock out every unit and stop zones
// - address 0..15; master and single-zone accept address 0 only
// - burner count 0..32 applied on burner error clear, count clear, restart
// - zone lockout when faulted burners reach threshold; 0 or above count disables
// - air check: switch off with blower off, then on with blower on
// - check enabled without assigned switch stalls at the on check
// - check disabled with assigned switch still monitors switch as interlock
// - stored results cleared on startup off or blower sync off, selectable
// - results kept while an assigned blower sync stays on, even when startup drops
// - sync-off clearing: interlock open with switch on discards results
// - temperature mode off, first-prepurge-only, every prepurge, or normal
// - mode off with both temperature inputs assigned locks out
//
// Local design decisions: the placing of the registers and the APB interface to the registers.
`include "interlock_group_regs.svh"
module interlock_group_supervisor (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // plant pins, asynchronous
  input wire interlock_group_pkg::plant_in_t plantPins,
  // peer link fault counts, same clock
  input wire interlock_group_pkg::peer_faults_t peerFaults,
  // decisions and interrupt
  output interlock_group_pkg::super_out_t decision,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////
  // two-flop synchroniser for plant pins
  // pins change with no regard to core_clk; only the second stage may be read,
  // so a metastable first stage never reaches the decision logic
  interlock_group_pkg::plant_in_t pinMeta;
  interlock_group_pkg::plant_in_t pin;
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      pinMeta <= '0;
      pin <= '0;
    end else begin
      pinMeta <= plantPins;
      pin <= pinMeta;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers
  // configuration word written by software; fields are decoded further down
  logic [31:0] cfgWord;
  logic [31:0] counts;
  logic [4:0] irqStatus;
  logic [4:0] irqEnable;
  logic [4:0] applZones;
  logic [5:0] applBurners;
  logic lockout;
  logic zoneLockout;
  logic overallStop;
  logic [2:0] lockCause;
  interlock_group_pkg::air_state_t airState;
  logic airOffSeen;
  logic airOnSeen;
  logic firstPurgeDone;
  logic prevBlowerSync;
  logic prevStartup;

  logic wrAccess;
  logic rdAccess;
  logic ctlReset;
  logic ctlLinkClr;
  logic ctlBurnClr;
  logic ctlCntClr;
  logic ctlRestart;

  // single-cycle apb: access phase always completes at once
  assign wrAccess = psel && penable && pwrite;
  assign rdAccess = psel && penable && !pwrite;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addrKnown(paddr);

  // decode for the error answer only; the read mux has its own case
  function automatic logic addrKnown(input logic [11:0] a);
    addrKnown = (a == `OFF_CONFIG) || (a == `OFF_COUNTS) || (a == `OFF_INPUTS) ||
                (a == `OFF_CONTROL) || (a == `OFF_STATE) || (a == `OFF_IRQ_STATUS) ||
                (a == `OFF_IRQ_CLEAR) || (a == `OFF_IRQ_ENABLE);
  endfunction

  // saturate a requested count into its legal range
  function automatic logic [5:0] clampCount(input logic [7:0] v, input logic [5:0] lo, input logic [5:0] hi);
    if (v < {2'h0, lo}) begin
      clampCount = lo;
    end else if (v > {2'h0, hi}) begin
      clampCount = hi;
    end else begin
      clampCount = v[5:0];
    end
  endfunction

  assign ctlReset = wrAccess && (paddr == `OFF_CONTROL) && pwdata[`CTL_RESET_BIT];
  assign ctlLinkClr = wrAccess && (paddr == `OFF_CONTROL) && pwdata[`CTL_LINKCLR_BIT];
  assign ctlBurnClr = wrAccess && (paddr == `OFF_CONTROL) && pwdata[`CTL_BURNCLR_BIT];
  assign ctlCntClr = wrAccess && (paddr == `OFF_CONTROL) && pwdata[`CTL_CNTCLR_BIT];
  assign ctlRestart = wrAccess && (paddr == `OFF_CONTROL) && pwdata[`CTL_RESTART_BIT];

  // configuration registers
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      cfgWord <= `RST_CONFIG;
      counts <= `RST_COUNTS;
      irqEnable <= 5'h00;
    end else if (wrAccess) begin
      // the counts word is stored as written; zone and burner counts apply at a clear or restart, thresholds at once
      // writes to unmapped offsets fall through and change nothing
      if (paddr == `OFF_CONFIG) cfgWord <= pwdata;
      if (paddr == `OFF_COUNTS) counts <= pwdata;
      if (paddr == `OFF_IRQ_ENABLE) irqEnable <= pwdata[4:0];
    end
  end

  // config field views
  interlock_group_pkg::role_t role;
  interlock_group_pkg::temp_mode_t tempMode;
  logic [3:0] stationAddr;
  logic airCheckEn;
  logic clearOnSync;
  logic airAssigned;
  logic syncAssigned;
  logic tempAssigned;
  // role code 3 is not a legal role; it locks out unless the base switch also reads 3
  assign role = interlock_group_pkg::role_t'(cfgWord[`CFG_ROLE_LSB +: 2]);
  assign stationAddr = cfgWord[`CFG_ADDR_LSB +: 4];
  assign airCheckEn = cfgWord[`CFG_AIRCHK_BIT];
  assign clearOnSync = cfgWord[`CFG_CLRSEL_BIT];
  assign tempMode = interlock_group_pkg::temp_mode_t'(cfgWord[`CFG_TEMPMODE_LSB +: 2]);
  assign airAssigned = cfgWord[`CFG_AIRASSIGN_BIT];
  assign syncAssigned = cfgWord[`CFG_SYNCASSIGN_BIT];
  assign tempAssigned = cfgWord[`CFG_TEMPASSIGN_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // applied counts: a written value only takes hold at a clear or restart
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      applZones <= 5'h01;
      applBurners <= 6'h00;
    end else begin
      if (ctlLinkClr || ctlCntClr || ctlRestart) begin
        // the clamp keeps 1..16, so the top bit of the six-bit result is always spare
        applZones <= 5'(clampCount(counts[`CNT_ZONES_LSB +: 8], 6'h01, `MAX_ZONES));
      end
      if (ctlBurnClr || ctlCntClr || ctlRestart) begin
        applBurners <= clampCount(counts[`CNT_BURNERS_LSB +: 8], 6'h00, `MAX_BURNERS);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // lockout causes, evaluated every cycle
  // causes are levels; the latches below hold them, so a cause that
  // disappears again still leaves the unit locked out until a reset
  logic [5:0] zoneThr;
  logic [5:0] burnThr;
  logic roleBad;
  logic addrBad;
  logic zoneEsc;
  logic burnEsc;
  logic multiEsc;
  logic tempBad;
  logic airTrip;
  logic anyCause;
  assign zoneThr = clampCount(counts[`CNT_ZONETHR_LSB +: 8], 6'h01, `MAX_ZONES);
  assign burnThr = clampCount(counts[`CNT_BURNTHR_LSB +: 8], 6'h00, `MAX_BURNERS);
  // single-zone ignores the base switch
  assign roleBad = (role != interlock_group_pkg::ROLE_SINGLE) && (pin.roleSwitch != role);
  assign addrBad = (role != interlock_group_pkg::ROLE_ZONE) && (stationAddr != 4'h0);
  // zones beyond the applied count cannot be counted as faulted
  assign zoneEsc = (role == interlock_group_pkg::ROLE_MASTER) &&
                   ({1'b0, peerFaults.zoneFaults} >= zoneThr) &&
                   (peerFaults.zoneFaults <= applZones) && (peerFaults.zoneFaults != 5'h00);
  assign burnEsc = (role != interlock_group_pkg::ROLE_MASTER) && (burnThr != 6'h00) &&
                   (burnThr <= applBurners) && (peerFaults.burnerFaults >= burnThr);
  // own fault plus one faulted zone also counts as two units
  assign multiEsc = (({1'b0, peerFaults.zoneFaults} + {5'h00, peerFaults.ownFault}) >= 6'h02);
  assign tempBad = (tempMode == interlock_group_pkg::TEMP_OFF) && tempAssigned;
  // switch acts as interlock whenever assigned and check is off
  assign airTrip = !airCheckEn && airAssigned && pin.blowerOn && !pin.airSwitch;
  assign anyCause = roleBad || addrBad || zoneEsc || burnEsc || multiEsc || tempBad || airTrip ||
                    peerFaults.ownFault;

  // latched lockouts; reset is refused while any cause remains
  // refusing the reset silently is safer than clearing and relatching at once,
  // which would let the decision outputs glitch low for a cycle
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      lockout <= 1'b0;
      zoneLockout <= 1'b0;
      overallStop <= 1'b0;
      lockCause <= 3'h0;
    end else if (ctlReset && !anyCause) begin
      // a master with faulted zones stays stopped until they reset first
      lockout <= 1'b0;
      zoneLockout <= 1'b0;
      overallStop <= 1'b0;
      lockCause <= 3'h0;
    end else begin
      if (anyCause) lockout <= 1'b1;
      if (burnEsc || (role == interlock_group_pkg::ROLE_ZONE && peerFaults.ownFault)) zoneLockout <= 1'b1;
      if (zoneEsc || multiEsc) overallStop <= 1'b1;
      if (roleBad) lockCause[0] <= 1'b1;
      if (addrBad || tempBad) lockCause[1] <= 1'b1;
      if (zoneEsc || multiEsc || burnEsc) lockCause[2] <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // air pressure switch startup check
  // edge detectors start at zero, the idle level of both pins after reset,
  // so no false falling edge follows a reset
  logic clearResults;
  logic syncFell;
  logic startFell;
  assign syncFell = prevBlowerSync && !pin.blowerSync;
  assign startFell = prevStartup && !pin.startup;
  // an assigned sync held on keeps results even when startup drops
  assign clearResults = clearOnSync ? (syncFell || (pin.interlockOpen && pin.airSwitch && airState == interlock_group_pkg::AIR_DONE))
                                    : (startFell && !(syncAssigned && pin.blowerSync));

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      prevBlowerSync <= 1'b0;
      prevStartup <= 1'b0;
    end else begin
      prevBlowerSync <= pin.blowerSync;
      prevStartup <= pin.startup;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n || ctlRestart) begin
      airState <= interlock_group_pkg::AIR_IDLE;
      airOffSeen <= 1'b0;
      airOnSeen <= 1'b0;
    end else if (clearResults) begin
      airState <= interlock_group_pkg::AIR_IDLE;
      airOffSeen <= 1'b0;
      airOnSeen <= 1'b0;
    end else begin
      case (airState)
        interlock_group_pkg::AIR_IDLE: begin
          if (pin.startup) begin
            airState <= airCheckEn ? interlock_group_pkg::AIR_OFF_CHECK : interlock_group_pkg::AIR_MONITOR;
          end
        end
        interlock_group_pkg::AIR_OFF_CHECK: begin
          if (!pin.blowerOn && !pin.airSwitch && airAssigned) begin
            airOffSeen <= 1'b1;
            airState <= interlock_group_pkg::AIR_ON_CHECK;
          end else if (!airAssigned) begin
            airState <= interlock_group_pkg::AIR_ON_CHECK;
          end
        end
        interlock_group_pkg::AIR_ON_CHECK: begin
          // no assigned switch means this step never completes
          if (airAssigned && airOffSeen && pin.blowerOn && pin.airSwitch) begin
            airOnSeen <= 1'b1;
            airState <= interlock_group_pkg::AIR_DONE;
          end
        end
        interlock_group_pkg::AIR_DONE: begin
          airState <= interlock_group_pkg::AIR_DONE;
        end
        interlock_group_pkg::AIR_MONITOR: begin
          if (!pin.startup) airState <= interlock_group_pkg::AIR_IDLE;
        end
        default: airState <= interlock_group_pkg::AIR_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // furnace temperature prepurge gating
  // hot furnace blocks prepurge unless mode is off; first-only mode lets the first one through
  logic purgeStart;
  assign purgeStart = decision.airCheckPass && !prevStartup && pin.startup;
  always_ff @(posedge core_clk) begin
    if (!reset_n || !pin.startup) begin
      firstPurgeDone <= 1'b0;
    end else if (decision.airCheckPass) begin
      firstPurgeDone <= 1'b1;
    end
  end

  logic tempGate;
  always_comb begin
    case (tempMode)
      interlock_group_pkg::TEMP_OFF: tempGate = 1'b1;
      interlock_group_pkg::TEMP_FIRST_ONLY: tempGate = !firstPurgeDone || !pin.hotTemp;
      interlock_group_pkg::TEMP_EVERY: tempGate = !pin.hotTemp;
      interlock_group_pkg::TEMP_NORMAL: tempGate = !pin.hotTemp;
      default: tempGate = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // decision outputs from flops
  // one extra cycle of latency buys glitch-free outputs towards the plant
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      decision <= '0;
    end else begin
      decision.lockout <= lockout;
      decision.zoneLockout <= zoneLockout;
      decision.overallStop <= overallStop;
      decision.blockBurners <= lockout || zoneLockout;
      decision.airCheckPass <= (airState == interlock_group_pkg::AIR_DONE && airOnSeen) ||
                               (airState == interlock_group_pkg::AIR_MONITOR);
      decision.prepurgeAllow <= tempGate && !lockout && !overallStop;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupts: lockout, zone lockout, overall stop, purge start, result clear
  // rising edges come from comparing each latch with its registered copy
  logic [4:0] irqEvents;
  assign irqEvents = {clearResults, purgeStart, overallStop && !decision.overallStop,
                      zoneLockout && !decision.zoneLockout, lockout && !decision.lockout};
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      irqStatus <= 5'h00;
    end else if (wrAccess && paddr == `OFF_IRQ_CLEAR) begin
      // a new event in the clear cycle survives
      irqStatus <= (irqStatus & ~pwdata[4:0]) | irqEvents;
    end else begin
      irqStatus <= irqStatus | irqEvents;
    end
  end
  assign irq = |(irqStatus & irqEnable);

  // read mux
  always_comb begin
    prdata = 32'h0000_0000;
    if (rdAccess) begin
      case (paddr)
        `OFF_CONFIG: prdata = cfgWord;
        `OFF_COUNTS: prdata = counts;
        `OFF_INPUTS: prdata = {24'h00_0000, pin};
        `OFF_STATE: prdata = {7'h00, // [31:25] spare
                              applBurners, // [24:19]
                              3'h0, // [18:16] spare
                              applZones, // [15:11]
                              lockCause, // [10:8]
                              airState, // [7:3]
                              overallStop, // [2]
                              zoneLockout, // [1]
                              lockout}; // [0]
        `OFF_IRQ_STATUS: prdata = {27'h000_0000, irqStatus};
        `OFF_IRQ_ENABLE: prdata = {27'h000_0000, irqEnable};
        default: prdata = 32'h0000_0000;
      endcase
    end
  end

endmodule

// >>> interlock_group_regs.svh
`ifndef INTERLOCK_GROUP_REGS_SVH
`define INTERLOCK_GROUP_REGS_SVH
// register byte offsets
`define OFF_CONFIG 12'h000
`define OFF_COUNTS 12'h004
`define OFF_INPUTS 12'h008
`define OFF_CONTROL 12'h00C
`define OFF_STATE 12'h010
`define OFF_IRQ_STATUS 12'h014
`define OFF_IRQ_CLEAR 12'h018
`define OFF_IRQ_ENABLE 12'h01C
// config fields
`define CFG_ROLE_LSB 0
`define CFG_ADDR_LSB 2
`define CFG_AIRCHK_BIT 6
`define CFG_CLRSEL_BIT 7
`define CFG_TEMPMODE_LSB 8
`define CFG_AIRASSIGN_BIT 10
`define CFG_SYNCASSIGN_BIT 11
`define CFG_TEMPASSIGN_BIT 12
// counts fields
`define CNT_ZONES_LSB 0
`define CNT_ZONETHR_LSB 8
`define CNT_BURNERS_LSB 16
`define CNT_BURNTHR_LSB 24
// control bits (write one to pulse)
`define CTL_RESET_BIT 0
`define CTL_LINKCLR_BIT 1
`define CTL_BURNCLR_BIT 2
`define CTL_CNTCLR_BIT 3
`define CTL_RESTART_BIT 4
// reset values
`define RST_CONFIG 32'h0000_0000
`define RST_COUNTS 32'h0000_0101
// zone and burner count limits
`define MAX_ZONES 6'h10
`define MAX_BURNERS 6'h20
`endif

// >>> interlock_group_pkg.sv
package interlock_group_pkg;
  typedef enum logic [1:0] {
    ROLE_MASTER = 2'h0,
    ROLE_ZONE = 2'h1,
    ROLE_SINGLE = 2'h2
  } role_t;

  typedef enum logic [1:0] {
    TEMP_OFF = 2'h0,
    TEMP_FIRST_ONLY = 2'h1,
    TEMP_EVERY = 2'h2,
    TEMP_NORMAL = 2'h3
  } temp_mode_t;

  typedef enum logic [4:0] {
    AIR_IDLE = 5'h01,
    AIR_OFF_CHECK = 5'h02,
    AIR_ON_CHECK = 5'h04,
    AIR_DONE = 5'h08,
    AIR_MONITOR = 5'h10
  } air_state_t;

  // plant-side inputs after synchronisation
  typedef struct packed {
    logic startup;
    logic blowerSync;
    logic blowerOn;
    logic airSwitch;
    logic interlockOpen;
    logic hotTemp;
    logic [1:0] roleSwitch;
  } plant_in_t;

  // fault counts reported by the peer link
  typedef struct packed {
    logic [4:0] zoneFaults;
    logic [5:0] burnerFaults;
    logic ownFault;
  } peer_faults_t;

  // supervisor decisions
  typedef struct packed {
    logic lockout;
    logic zoneLockout;
    logic overallStop;
    logic blockBurners;
    logic prepurgeAllow;
    logic airCheckPass;
  } super_out_t;
endpackage

// >>> interlock_group_supervisor_sva.sv
`include "interlock_group_regs.svh"
module interlock_group_supervisor_sva (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // plant and peers
  input wire interlock_group_pkg::plant_in_t plantPins,
  input wire interlock_group_pkg::peer_faults_t peerFaults,
  // decisions
  input wire interlock_group_pkg::super_out_t decision,
  input wire logic irq
);
  logic [3:0] clrHist;
  logic [4:0] enMirror;
  logic wrCycle;
  assign wrCycle = psel && penable && pwrite;
  // recent reset or restart writes; a latch may only drop shortly after one
  always_ff @(posedge core_clk) begin
    if (!reset_n) clrHist <= 4'h0;
    else clrHist <= {clrHist[2:0], wrCycle && paddr == `OFF_CONTROL && (pwdata[0] || pwdata[4])};
  end
  // copy of the interrupt enables, kept to prove masking
  always_ff @(posedge core_clk) begin
    if (!reset_n) enMirror <= 5'h00;
    else if (wrCycle && paddr == `OFF_IRQ_ENABLE) enMirror <= pwdata[4:0];
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  sequence s_access;
    psel && penable;
  endsequence
  pready_high_a: assert property (pready) else $error("pready low");
  err_in_access_a: assert property (pslverr |-> psel && penable) else $error("pslverr outside access");
  unmapped_read_a: assert property (s_access ##0 (!pwrite && paddr >= 12'h020) |-> pslverr && prdata == 32'h0)
    else $error("unmapped read not refused");
  reset_quiet_a: assert property ($rose(reset_n) |-> decision == '0 && !irq) else $error("outputs busy after reset");
  lock_latch_a: assert property ($fell(decision.lockout) |-> clrHist != 4'h0) else $error("lockout dropped");
  zone_latch_a: assert property ($fell(decision.zoneLockout) |-> clrHist != 4'h0) else $error("zone drop");
  stop_latch_a: assert property ($fell(decision.overallStop) |-> clrHist != 4'h0) else $error("stop drop");
  air_pass_a: assert property ($rose(decision.airCheckPass) |-> $past(plantPins.airSwitch, 3)
    && $past(plantPins.blowerOn, 3)) else $error("air pass without switch on");
  irq_mask_a: assert property (enMirror == 5'h00 |-> !irq) else $error("masked irq raised");
endmodule
bind interlock_group_supervisor interlock_group_supervisor_sva chk (.core_clk(core_clk), .reset_n(reset_n),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .plantPins(plantPins), .peerFaults(peerFaults),
  .decision(decision), .irq(irq));

// >>> peer_link_model.sv
module peer_link_model (
  // clock
  input wire logic core_clk,
  // commands from the bench
  input wire logic [4:0] zoneCmd,
  input wire logic [5:0] burnCmd,
  // fault counts towards the supervisor
  output interlock_group_pkg::peer_faults_t peerFaults
);
  timeunit 1ns;
  timeprecision 1ps;
  // counts move on the edge like a link frame; faulted zones clear only when told to
  always_ff @(posedge core_clk) begin
    peerFaults <= '{zoneFaults: zoneCmd, burnerFaults: burnCmd, ownFault: 1'b0};
  end
endmodule

// >>> interlock_group_supervisor_test.sv
`include "interlock_group_regs.svh"
module interlock_group_supervisor_test;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [31:0] val; logic [31:0] mask; logic err;} exp_t;
  logic core_clk, reset_n, psel, penable, pwrite, pready, pslverr, irq, probeReq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [4:0] zoneCmd;
  logic [5:0] burnCmd;
  interlock_group_pkg::plant_in_t plantPins;
  interlock_group_pkg::peer_faults_t peerFaults;
  interlock_group_pkg::super_out_t decision;
  exp_t expQ[$];
  exp_t cur;
  int errors, checks_done, seed, i;
  logic [7:0] rows[4][3];
  interlock_group_supervisor uut (.core_clk(core_clk), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .plantPins(plantPins), .peerFaults(peerFaults), .decision(decision), .irq(irq));
  peer_link_model peer (.core_clk(core_clk), .zoneCmd(zoneCmd), .burnCmd(burnCmd), .peerFaults(peerFaults));
  ////////////////////////////////////////////////////////////////////////
  // clock
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  // one apb transfer, held until pready is seen high
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1) @(posedge core_clk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] v, input logic [31:0] m, input logic e);
    expQ.push_back('{v, m, e});
    bus(1'b0, a, 32'h0);
  endtask
  // note {irq, decision} under a mask for the monitor
  task automatic look(input logic [6:0] v, input logic [6:0] m);
    expQ.push_back('{{25'h0, v}, {25'h0, m}, 1'b0});
    @(posedge core_clk);
    probeReq <= 1'b1;
    @(posedge core_clk);
    probeReq <= 1'b0;
  endtask
  // pins pass two sync flops and two registers, so allow eight edges
  task automatic pins(input logic [7:0] p);
    @(posedge core_clk);
    plantPins <= interlock_group_pkg::plant_in_t'(p);
    repeat (8) @(posedge core_clk);
  endtask
  task automatic hw_reset();
    @(posedge core_clk);
    reset_n <= 1'b0;
    repeat (8) @(posedge core_clk);
    reset_n <= 1'b1;
  endtask
  task automatic end_of_test();
    $display("errors %0d checks %0d", errors, checks_done);
    if (errors == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // monitor: each read or probe takes the oldest note
  always @(posedge core_clk) begin
    if ((psel && penable && pready && !pwrite) === 1'b1 || probeReq === 1'b1) begin
      cur = expQ.pop_front();
      checks_done++;
      if ((((probeReq === 1'b1) ? {25'h0, irq, decision} : prdata) & cur.mask) !== cur.val
          || (probeReq !== 1'b1 && pslverr !== cur.err)) begin
        errors++;
        $display("unexpected at %0t: result differs from %h", $time, cur.val);
      end
    end
  end
  // watchdog, far beyond the few hundred edges the run needs
  initial begin
    repeat (20000) @(posedge core_clk);
    errors++;
    end_of_test();
  end
  ////////////////////////////////////////////////////////////////////////
  // burner threshold, faults, expected zone lockout; zero or above count disables
  initial begin
    rows = '{'{8'h00, 8'h04, 8'h00}, '{8'h05, 8'h04, 8'h00}, '{8'h02, 8'h01, 8'h00}, '{8'h02, 8'h02, 8'h01}};
    seed = 32'h359e17dc;
    {reset_n, psel, penable, pwrite, probeReq} = 5'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    plantPins = '0;
    zoneCmd = 5'h00;
    burnCmd = 6'h00;
    repeat (8) @(posedge core_clk);
    reset_n <= 1'b1;
    rd(`OFF_CONFIG, `RST_CONFIG, 32'hFFFFFFFF, 1'b0);
    rd(`OFF_COUNTS, `RST_COUNTS, 32'hFFFFFFFF, 1'b0);
    bus(1'b1, 12'h020, 32'hFFFFFFFF);
    rd(12'h020, 32'h0, 32'hFFFFFFFF, 1'b1);
    // role mismatch, refused reset, then fixed switch and reset; irq masked and cleared
    bus(1'b1, `OFF_IRQ_ENABLE, 32'h1);
    pins(8'h01);
    look(7'h60, 7'h60);
    bus(1'b1, `OFF_CONTROL, 32'h1);
    look(7'h60, 7'h60);
    pins(8'h00);
    bus(1'b1, `OFF_CONTROL, 32'h1);
    look(7'h40, 7'h60);
    bus(1'b1, `OFF_IRQ_ENABLE, 32'h0);
    look(7'h00, 7'h40);
    bus(1'b1, `OFF_IRQ_CLEAR, 32'h1F);
    bus(1'b1, `OFF_IRQ_ENABLE, 32'h1);
    look(7'h00, 7'h40);
    rd(`OFF_IRQ_STATUS, 32'h0, 32'h1, 1'b0);
    // temperature mode off with both inputs assigned
    hw_reset();
    bus(1'b1, `OFF_CONFIG, 32'h1000);
    repeat (6) @(posedge core_clk);
    look(7'h20, 7'h20);
    // master: zone count applied on restart, stop at threshold, recovery order
    hw_reset();
    bus(1'b1, `OFF_COUNTS, 32'h0204);
    rd(`OFF_STATE, 32'h0800, 32'hF800, 1'b0);
    bus(1'b1, `OFF_CONTROL, 32'h10);
    rd(`OFF_STATE, 32'h2000, 32'hF800, 1'b0);
    zoneCmd <= 5'($random(seed)) & 5'h01;
    repeat (6) @(posedge core_clk);
    look(7'h00, 7'h28);
    zoneCmd <= 5'h02;
    repeat (6) @(posedge core_clk);
    look(7'h2C, 7'h2C);
    bus(1'b1, `OFF_CONTROL, 32'h1);
    look(7'h28, 7'h28);
    zoneCmd <= 5'h00;
    bus(1'b1, `OFF_CONTROL, 32'h1);
    repeat (4) @(posedge core_clk);
    look(7'h02, 7'h2E);
    for (i = 0; i < 4; i++) begin
      hw_reset();
      burnCmd <= 6'h00;
      pins(8'h01);
      bus(1'b1, `OFF_CONFIG, 32'h1);
      bus(1'b1, `OFF_COUNTS, {rows[i][0], 8'h04, 8'h01, 8'h01});
      bus(1'b1, `OFF_CONTROL, 32'h10);
      burnCmd <= rows[i][1][5:0];
      repeat (6) @(posedge core_clk);
      look({2'h0, rows[i][2][0], 4'h0}, 7'h10);
    end
    // air check off then on, kept while sync stays on, dropped when sync falls
    hw_reset();
    bus(1'b1, `OFF_CONFIG, 32'h0CC2);
    pins(8'h80);
    look(7'h00, 7'h01);
    pins(8'hF0);
    look(7'h01, 7'h01);
    pins(8'h70);
    look(7'h01, 7'h01);
    pins(8'h30);
    look(7'h00, 7'h01);
    // enabled check without an assigned switch never passes
    hw_reset();
    bus(1'b1, `OFF_CONFIG, 32'h08C2);
    pins(8'h80);
    pins(8'hF0);
    look(7'h00, 7'h01);
    repeat (4) @(posedge core_clk);
    end_of_test();
  end
endmodule
